// ### test/tb.sv
// self-checking bench for the mode register bank
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
   $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module tb;
   logic       clk, srst, ptr_load, wr_strobe, rd_strobe;
   logic       volt_select_lo, volt_select_hi;
   logic       uvlo_logic_supply, uvlo_main_supply_input;
   logic       forced_pwm, clock_follow_en;
   logic [7:0] ptr_byte, wr_byte, rd_data, reg_pointer, d;
   logic [7:0] mode_setting_select_11;
   logic [1:0] active_mode;
   logic [5:0] voltage_code;
   logic [7:0] exp_reg [4];
   int         failures = 0;
   int         compares = 0;
   int         cyc = 0;
   vidmr_regs uut (.*);
   vidmr_host host (.*);
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // the tests need well under 1500 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         failures++;
         end_sim();
      end
   end
   task end_sim;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task pt(input logic [7:0] p); host.xfer(0, p, d); endtask
   task wr(input logic [7:0] b); host.xfer(1, b, d); endtask
   task rd(input logic [7:0] e); host.xfer(2, 8'h00, d); `CHK(d, e) endtask
   task out(input logic [7:0] e);
      `CHK({forced_pwm, clock_follow_en, voltage_code}, e)
   endtask
   // pins need about five edges through the synchroniser
   task pins(input logic [1:0] m);
      @(posedge clk);
      {volt_select_hi, volt_select_lo} <= m;
      repeat (8) @(posedge clk);
   endtask
   initial
   begin
      srst = 1'b1;
      {volt_select_hi, volt_select_lo} = 2'h0;
      {uvlo_logic_supply, uvlo_main_supply_input} = 2'h0;
      mode_setting_select_11 = 8'h5a;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      repeat (6) @(posedge clk);
      exp_reg = '{vidmr_pkg::RST_MODE_00, vidmr_pkg::RST_MODE_01,
                  vidmr_pkg::RST_MODE_10, 8'h5a};
      out(exp_reg[0]);
      pt(8'h00);
      for (int i = 0; i < 4; i++) rd(exp_reg[i]);
      rd(vidmr_pkg::RD_UNMAPPED);
      $display("test reset done");
      // block write runs past the bank; the pointer 3 byte is dropped
      exp_reg[0] = 8'h41;
      exp_reg[1] = 8'hc2;
      exp_reg[2] = 8'h3f;
      pt(8'h00);
      wr(8'h41);
      out(8'h41);
      for (int i = 1; i < 4; i++) wr(exp_reg[i % 3]);
      pt(8'h00);
      for (int i = 0; i < 4; i++) rd(exp_reg[i]);
      $display("test write done");
      for (int m = 3; m >= 0; m--)
      begin
         pins(m[1:0]);
         `CHK(active_mode, m[1:0])
         out(exp_reg[m]);
      end
      $display("test select done");
      // either supply alone reloads all three defaults
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clk);
         {uvlo_logic_supply, uvlo_main_supply_input} <= 2'h1 << k;
         repeat (8) @(posedge clk);
         {uvlo_logic_supply, uvlo_main_supply_input} <= 2'h0;
         repeat (8) @(posedge clk);
         out(vidmr_pkg::RST_MODE_00);
         pt(8'h01);
         rd(vidmr_pkg::RST_MODE_01);
         rd(vidmr_pkg::RST_MODE_10);
         pt(8'h00);
         // dirty all three so the next lockout has something to reload
         for (int i = 0; i < 3; i++) wr(8'h3f);
      end
      $display("test lockout done");
      end_sim();
   end
endmodule
bind vidmr_regs vidmr_chk chk (.*);

// ### test/vidmr_chk.sv
// concurrent checks on the mode register bank ports
`timescale 1ns/10ps
module vidmr_chk (
   // clock and reset
   input wire logic       clk,
   input wire logic       srst,
   // byte port
   input wire logic       ptr_load,
   input wire logic [7:0] ptr_byte,
   input wire logic       wr_strobe,
   input wire logic [7:0] wr_byte,
   input wire logic       rd_strobe,
   input wire logic [7:0] rd_data,
   input wire logic [7:0] reg_pointer,
   input wire logic [7:0] mode_setting_select_11,
   // pins
   input wire logic       volt_select_lo,
   input wire logic       volt_select_hi,
   input wire logic       uvlo_logic_supply,
   input wire logic       uvlo_main_supply_input,
   // converter side
   input wire logic [1:0] active_mode,
   input wire logic       forced_pwm,
   input wire logic       clock_follow_en,
   input wire logic [5:0] voltage_code
);
   wire [7:0] setting = {forced_pwm, clock_follow_en, voltage_code};
   wire       lock = uvlo_logic_supply | uvlo_main_supply_input;
   wire       step = (wr_strobe | rd_strobe) & ~ptr_load;
   wire [1:0] pins = {volt_select_hi, volt_select_lo};
   logic [2:0] calm_reg;
   logic [2:0] lock_reg;
   // saturating counts so checks skip the pin synchroniser latency
   always_ff @(posedge clk)
   begin
      calm_reg <= (srst | lock | (pins != active_mode)) ? 3'h0
                  : calm_reg + {2'h0, calm_reg != 3'h7};
      lock_reg <= (srst | !lock) ? 3'h0
                  : lock_reg + {2'h0, lock_reg != 3'h7};
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence settled;
      $stable(pins) [*6];
   endsequence
   a_reset_vals: assert property (disable iff (1'b0) srst |=>
      rd_data == 8'h00 && reg_pointer == 8'h00 && setting == 8'hb4)
      else $error("reset values wrong");
   a_ptr_load: assert property (ptr_load |=>
      reg_pointer == $past(ptr_byte)) else $error("pointer not loaded");
   a_ptr_step: assert property (step |=>
      reg_pointer == $past(reg_pointer) + 8'h01)
      else $error("pointer did not step");
   a_read_fourth: assert property (rd_strobe && !ptr_load &&
      reg_pointer == 8'h03 |=> rd_data == $past(mode_setting_select_11))
      else $error("fourth register read wrong");
   a_read_unmapped: assert property (rd_strobe && !ptr_load &&
      reg_pointer > 8'h03 |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
   a_write_apply: assert property (calm_reg == 3'h7 && step &&
      wr_strobe && active_mode != 2'h3 &&
      reg_pointer == {6'h0, active_mode} |=> setting == $past(wr_byte))
      else $error("active write not applied");
   a_lock_default: assert property (lock_reg == 3'h7 &&
      active_mode == 2'h0 |-> setting == vidmr_pkg::RST_MODE_00)
      else $error("lockout did not reload");
   a_select_follow: assert property (settled |->
      active_mode == pins) else $error("mode select not followed");
endmodule

// ### test/vidmr_host.sv
// host model of the serial engine byte port
`timescale 1ns/10ps
module vidmr_host (
   // clock
   input  wire logic       clk,
   // byte port toward the bank
   output logic            ptr_load,
   output logic      [7:0] ptr_byte,
   output logic            wr_strobe,
   output logic      [7:0] wr_byte,
   output logic            rd_strobe,
   input  wire logic [7:0] rd_data
);
   initial
   begin
      {ptr_load, wr_strobe, rd_strobe} = 3'h0;
      ptr_byte = 8'h00;
      wr_byte = 8'h00;
   end
   // k 0 pointer, 1 write, 2 read; released bytes show the inverse
   task automatic xfer(input int k, input logic [7:0] b,
                       output logic [7:0] d);
      @(posedge clk);
      ptr_load <= (k == 0); // pointer byte first
      wr_strobe <= (k == 1); // each data byte steps the pointer
      rd_strobe <= (k == 2);
      ptr_byte <= b;
      wr_byte <= b;
      @(posedge clk);
      {ptr_load, wr_strobe, rd_strobe} <= 3'h0;
      ptr_byte <= ~b;
      wr_byte <= ~b;
      // rd_data is launched by the strobe edge; take it once it stands
      @(posedge clk);
      d = rd_data;
   endtask
endmodule

// ### verilog/vidmr_pin_sync.sv
// three-flop pin synchroniser that accepts a change once stages agree
`timescale 1ns/10ps
module vidmr_pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             srst,
   // asynchronous pins
   input  wire logic [WIDTH-1:0] pin_in,
   // filtered level
   output logic      [WIDTH-1:0] level_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] stage2_reg;
   logic [WIDTH-1:0] stage3_reg;
   logic [WIDTH-1:0] level_next;

   // per bit, take the new value only when stage 2 and 3 agree
   assign level_next = (stage2_reg & ~(stage2_reg ^ stage3_reg))
                     | (level_out & (stage2_reg ^ stage3_reg));

   // meta_reg is read only by stage2_reg
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         meta_reg   <= INIT;
         stage2_reg <= INIT;
         stage3_reg <= INIT;
         level_out  <= INIT;
      end
      else
      begin
         meta_reg   <= pin_in;
         stage2_reg <= meta_reg;
         stage3_reg <= stage2_reg;
         level_out  <= level_next;
      end
   end
endmodule

// ### verilog/vidmr_pkg.sv
// constants for the voltage-select mode register bank
package vidmr_pkg;
   // register pointers
   localparam logic [7:0] PTR_MODE_00 = 8'h00;
   localparam logic [7:0] PTR_MODE_01 = 8'h01;
   localparam logic [7:0] PTR_MODE_10 = 8'h02;
   localparam logic [7:0] PTR_MODE_11 = 8'h03;
   // reset values
   localparam logic [7:0] RST_MODE_00 = 8'hb4;
   localparam logic [7:0] RST_MODE_01 = 8'h1e;
   localparam logic [7:0] RST_MODE_10 = 8'hb0;
   // field positions inside a mode register
   localparam int FORCED_PWM_BIT   = 7;
   localparam int CLOCK_FOLLOW_BIT = 6;
   localparam int VCODE_MSB        = 5;
   localparam int VCODE_LSB        = 0;
   // read data for pointers this bank does not hold
   localparam logic [7:0] RD_UNMAPPED = 8'h00;
   // select pin encodings {hi, lo}
   localparam logic [1:0] SEL_00 = 2'h0;
   localparam logic [1:0] SEL_01 = 2'h1;
   localparam logic [1:0] SEL_10 = 2'h2;
   localparam logic [1:0] SEL_11 = 2'h3;
   // synchroniser depth for pin inputs
   localparam int SYNC_STAGES = 3;
endpackage

// ### verilog/vidmr_regs.sv
// mode register bank with voltage-select routing to the converter
`timescale 1ns/10ps
module vidmr_regs (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // byte port from the serial engine, one-cycle strobes
   input  wire logic       ptr_load,
   input  wire logic [7:0] ptr_byte,
   input  wire logic       wr_strobe,
   input  wire logic [7:0] wr_byte,
   input  wire logic       rd_strobe,
   output logic      [7:0] rd_data,
   output logic      [7:0] reg_pointer,
   // fourth mode register, held by a neighbouring block on this clock
   input  wire logic [7:0] mode_setting_select_11,
   // pins
   input  wire logic       volt_select_lo,
   input  wire logic       volt_select_hi,
   input  wire logic       uvlo_logic_supply,
   input  wire logic       uvlo_main_supply_input,
   // settings to the converter
   output logic       [1:0] active_mode,
   output logic             forced_pwm,
   output logic             clock_follow_en,
   output logic       [5:0] voltage_code
);
   logic [7:0] mode_setting_select_00;
   logic [7:0] mode_setting_select_01;
   logic [7:0] mode_setting_select_10;
   logic [7:0] mode_00_next;
   logic [7:0] mode_01_next;
   logic [7:0] mode_10_next;
   logic [7:0] pointer_next;
   logic [1:0] select_level;
   logic [1:0] uvlo_level;
   logic       uvlo_any;
   logic       wr_00;
   logic       wr_01;
   logic       wr_10;
   logic [7:0] selected_next;
   logic [7:0] rd_next;

   // field views of the stored registers, read back through the read mux
   logic       forced_pwm_sel_a;
   logic       forced_pwm_sel_b;
   logic       forced_pwm_sel_c;
   logic       clock_follow_en_a;
   logic       clock_follow_en_b;
   logic       clock_follow_en_c;
   logic [5:0] voltage_code_a;
   logic [5:0] voltage_code_b;
   logic [5:0] voltage_code_c;

   // pin inputs come from outside the clock domain
   vidmr_pin_sync #(
      .WIDTH (2),
      .INIT  (2'h0)
   ) u_select_sync (
      .clk       (clk),
      .srst      (srst),
      .pin_in    ({volt_select_hi, volt_select_lo}),
      .level_out (select_level)
   );

   // lockout syncs start asserted so registers stay at defaults
   vidmr_pin_sync #(
      .WIDTH (2),
      .INIT  (2'h3)
   ) u_uvlo_sync (
      .clk       (clk),
      .srst      (srst),
      .pin_in    ({uvlo_main_supply_input, uvlo_logic_supply}),
      .level_out (uvlo_level)
   );

   // either supply under lockout forces defaults
   assign uvlo_any = |uvlo_level;

   // write decode; the strobe marks the data byte acknowledge
   assign wr_00 = wr_strobe & ~ptr_load
                & (reg_pointer == vidmr_pkg::PTR_MODE_00);
   assign wr_01 = wr_strobe & ~ptr_load
                & (reg_pointer == vidmr_pkg::PTR_MODE_01);
   assign wr_10 = wr_strobe & ~ptr_load
                & (reg_pointer == vidmr_pkg::PTR_MODE_10);

   // next register contents; lockout wins over a write
   assign mode_00_next = uvlo_any ? vidmr_pkg::RST_MODE_00
                       : wr_00    ? wr_byte : mode_setting_select_00;
   assign mode_01_next = uvlo_any ? vidmr_pkg::RST_MODE_01
                       : wr_01    ? wr_byte : mode_setting_select_01;
   assign mode_10_next = uvlo_any ? vidmr_pkg::RST_MODE_10
                       : wr_10    ? wr_byte : mode_setting_select_10;

   // pointer: a new pointer byte wins, otherwise each data byte steps it
   assign pointer_next = ptr_load ? ptr_byte
                       : (wr_strobe | rd_strobe)
                       ? 8'(reg_pointer + 8'h01)
                       : reg_pointer;

   // selection uses next values of the three stored modes so a write to an
   // active stored mode lands on the outputs at the same edge as the register itself
   assign selected_next =
      (select_level == vidmr_pkg::SEL_00) ? mode_00_next
    : (select_level == vidmr_pkg::SEL_01) ? mode_01_next
    : (select_level == vidmr_pkg::SEL_10) ? mode_10_next
    : mode_setting_select_11;

   // read mux; pointer 3 reads the neighbouring register, pointers above it read as zero
   assign rd_next =
      (reg_pointer == vidmr_pkg::PTR_MODE_00)
      ? {forced_pwm_sel_a, clock_follow_en_a, voltage_code_a}
    : (reg_pointer == vidmr_pkg::PTR_MODE_01)
      ? {forced_pwm_sel_b, clock_follow_en_b, voltage_code_b}
    : (reg_pointer == vidmr_pkg::PTR_MODE_10)
      ? {forced_pwm_sel_c, clock_follow_en_c, voltage_code_c}
    : (reg_pointer == vidmr_pkg::PTR_MODE_11) ? mode_setting_select_11
    : vidmr_pkg::RD_UNMAPPED;

   // field views of each stored register
   assign forced_pwm_sel_a  =
      mode_setting_select_00[vidmr_pkg::FORCED_PWM_BIT];
   assign forced_pwm_sel_b  =
      mode_setting_select_01[vidmr_pkg::FORCED_PWM_BIT];
   assign forced_pwm_sel_c  =
      mode_setting_select_10[vidmr_pkg::FORCED_PWM_BIT];
   assign clock_follow_en_a =
      mode_setting_select_00[vidmr_pkg::CLOCK_FOLLOW_BIT];
   assign clock_follow_en_b =
      mode_setting_select_01[vidmr_pkg::CLOCK_FOLLOW_BIT];
   assign clock_follow_en_c =
      mode_setting_select_10[vidmr_pkg::CLOCK_FOLLOW_BIT];
   assign voltage_code_a =
      mode_setting_select_00[vidmr_pkg::VCODE_MSB:vidmr_pkg::VCODE_LSB];
   assign voltage_code_b =
      mode_setting_select_01[vidmr_pkg::VCODE_MSB:vidmr_pkg::VCODE_LSB];
   assign voltage_code_c =
      mode_setting_select_10[vidmr_pkg::VCODE_MSB:vidmr_pkg::VCODE_LSB];

   // register storage; srst and lockout both load defaults
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         mode_setting_select_00 <= vidmr_pkg::RST_MODE_00;
         mode_setting_select_01 <= vidmr_pkg::RST_MODE_01;
         mode_setting_select_10 <= vidmr_pkg::RST_MODE_10;
         reg_pointer            <= 8'h00;
         rd_data                <= 8'h00;
      end
      else
      begin
         mode_setting_select_00 <= mode_00_next;
         mode_setting_select_01 <= mode_01_next;
         mode_setting_select_10 <= mode_10_next;
         reg_pointer            <= pointer_next;
         if (rd_strobe & ~ptr_load)
         begin
            rd_data <= rd_next;
         end
      end
   end

   // converter outputs, re-selected every cycle from the synced pins
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         active_mode     <= vidmr_pkg::SEL_00;
         forced_pwm      <= vidmr_pkg::RST_MODE_00[vidmr_pkg::FORCED_PWM_BIT];
         clock_follow_en <=
            vidmr_pkg::RST_MODE_00[vidmr_pkg::CLOCK_FOLLOW_BIT];
         voltage_code    <=
            vidmr_pkg::RST_MODE_00[vidmr_pkg::VCODE_MSB:vidmr_pkg::VCODE_LSB];
      end
      else
      begin
         active_mode     <= select_level;
         forced_pwm      <= selected_next[vidmr_pkg::FORCED_PWM_BIT];
         clock_follow_en <=
            selected_next[vidmr_pkg::CLOCK_FOLLOW_BIT];
         voltage_code    <=
            selected_next[vidmr_pkg::VCODE_MSB:vidmr_pkg::VCODE_LSB];
      end
   end
endmodule
